// file: rtl/rrsir_dev.sv
// receive status and interrupt registers with sixteen byte receive buffer
`timescale 1ns/10ps
`include "rrsir_consts.svh"
module rrsir_dev
    import rrsir_pkg::*;
(
    input wire logic i_sys_clk,          // system clock
    input wire logic i_rst,              // synchronous reset, active high
    rrsir_if.dev bus,                    // host register port
    input wire logic i_sop,              // start of packet pulse
    input wire logic i_len_valid,        // length field arrived pulse
    input wire logic [7:0] i_len,        // received length field
    input wire logic i_len_bad,          // length field corrupted
    input wire logic i_byte_valid,       // payload byte arrived pulse
    input wire logic [7:0] i_byte,       // payload byte
    input wire logic i_eop,              // packet end pulse with status below
    input wire logic i_crc_bad,          // checksum wrong
    input wire logic i_crc_zero,         // checksum used zero seed
    input wire logic i_early_end,        // end before length and checksum
    input wire logic i_is_ack,           // received packet is an acknowledge
    input wire logic i_expect_ack,       // acknowledge was expected
    input wire logic i_code64,           // 64-chip code in use
    input wire logic [1:0] i_mode,       // data mode of packet
    input wire logic i_xact_mode,        // transaction mode on
    input wire logic i_ack_sent,         // acknowledge transmitted pulse
    output logic o_rx_active             // device is in receive mode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0][7:0] mem_lo;   // buffer words 0..7
        logic [7:0][7:0] mem_hi;   // buffer words 8..15
        logic [3:0] wptr;          // write pointer
        logic [3:0] rptr;          // read pointer
        logic [4:0] level;         // bytes held
        logic ow, berr, rxc, rxe;  // sticky flags
        logic go;                  // receive start pending
        logic active;              // packet in progress
        logic ack_wait;            // complete waits for ack send
        logic [7:0] stat;          // packet status byte
        logic [7:0] count;         // payload byte count
        logic [7:0] len;           // length field
        logic [7:0] rdata;         // read data
        logic rvalid;              // read valid
        logic [7:0] bdata;         // popped byte
        logic bvalid;              // pop valid
    } rrsir_dstate_t;
    rrsir_dstate_t st_reg;
    rrsir_dstate_t st_next;
    logic [7:0] flags;        // assembled interrupt register
    logic pop_ok;             // legal pop
    logic push_ok;            // legal push
    logic sop_take;           // start of packet accepted
    logic [15:0][7:0] mem;    // buffer view
    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    // interrupt register image, reserved bit reads zero
    always_comb begin
        flags = 8'h00;
        flags[`RRSIR_BIT_OW] = st_reg.ow;
        flags[`RRSIR_BIT_FULL] = (st_reg.level == `RRSIR_BUF_DEPTH);
        flags[`RRSIR_BIT_HALF] = (st_reg.level >= `RRSIR_HALF_LEVEL);
        flags[`RRSIR_BIT_NE] = (st_reg.level != 5'h00);
        flags[`RRSIR_BIT_BERR] = st_reg.berr;
        flags[`RRSIR_BIT_RXC] = st_reg.rxc;
        flags[`RRSIR_BIT_RXE] = st_reg.rxe;
    end
    assign mem = {st_reg.mem_hi, st_reg.mem_lo};
    assign pop_ok = bus.buf_rd && (st_reg.level != 5'h00);
    // without overwrite, sop ignored while buffer holds data
    assign sop_take = i_sop && (bus.ow_en || st_reg.level == 5'h00 || !st_reg.go);
    assign push_ok = i_byte_valid && st_reg.active
        && (st_reg.level != `RRSIR_BUF_DEPTH);
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.bvalid = 1'b0;
        // host sets start, device clears it at packet end
        if (bus.rx_start) begin
            st_next.go = 1'b1;
        end
        // buffer pop
        if (pop_ok) begin
            st_next.bdata = mem[st_reg.rptr];
            st_next.bvalid = 1'b1;
            st_next.rptr = st_reg.rptr + 4'h1;
        end
        // register reads; interrupt register read clears complete and error
        if (bus.rd) begin
            st_next.rvalid = 1'b1;
            case (bus.addr)
                `RRSIR_ADDR_IRQ: begin
                    st_next.rdata = flags;
                    st_next.rxc = 1'b0;
                    st_next.rxe = 1'b0;
                end
                `RRSIR_ADDR_STAT: st_next.rdata = st_reg.stat;
                `RRSIR_ADDR_COUNT: st_next.rdata = st_reg.count;
                `RRSIR_ADDR_LEN: st_next.rdata = st_reg.len;
                default: st_next.rdata = 8'h00;
            endcase
        end
        // any write to the interrupt register clears overwrite
        if (bus.wr && bus.addr == `RRSIR_ADDR_IRQ) begin
            st_next.ow = 1'b0;
        end
        // start of packet
        if (sop_take && st_reg.go) begin
            st_next.active = 1'b1;
            st_next.stat[5] = 1'b0;
            // start with receive armed clears buffer error
            st_next.berr = 1'b0;
            if (st_reg.level != 5'h00) begin
                st_next.ow = 1'b1;
                st_next.level = 5'h00;
                st_next.rptr = st_reg.wptr;
            end
        end else if (i_sop && st_reg.go && !sop_take) begin
            // packet dropped because buffer still occupied
            st_next.rxe = 1'b1;
        end
        // length capture; corrupt field loads zero except gfsk
        if (i_len_valid && st_reg.active) begin
            st_next.count = `RRSIR_RESET_BYTE;
            if (i_len_bad && i_mode != RRSIR_MODE_GFSK) begin
                st_next.len = `RRSIR_RESET_BYTE;
                st_next.rxe = 1'b1;
            end else begin
                st_next.len = i_len;
            end
        end else if (push_ok) begin
            st_next.count = st_reg.count + 8'h01;
        end
        // buffer push and level tracking
        if (push_ok) begin
            if (st_reg.wptr[3]) begin
                st_next.mem_hi[st_reg.wptr[2:0]] = i_byte;
            end else begin
                st_next.mem_lo[st_reg.wptr[2:0]] = i_byte;
            end
            st_next.wptr = st_reg.wptr + 4'h1;
        end
        if (!(sop_take && st_reg.go && st_reg.level != 5'h00)) begin
            st_next.level = st_reg.level + {4'h0, push_ok} - {4'h0, pop_ok};
        end else begin
            st_next.level = {4'h0, push_ok};
        end
        // empty pop or overflow sets buffer error
        if ((bus.buf_rd && st_reg.level == 5'h00)
            || (i_byte_valid && st_reg.active && st_reg.level == `RRSIR_BUF_DEPTH)) begin
            st_next.berr = 1'b1;
        end
        // packet end
        if (i_eop && st_reg.active) begin
            st_next.active = 1'b0;
            st_next.go = 1'b0;
            st_next.stat[7] = i_is_ack;
            st_next.stat[6] = (i_is_ack != i_expect_ack);
            st_next.stat[5] = i_early_end;
            st_next.stat[4] = i_crc_zero;
            st_next.stat[3] = i_crc_bad;
            if (i_crc_bad || i_early_end || (i_is_ack != i_expect_ack)) begin
                st_next.rxe = 1'b1;
            end else begin
                // code length of last good packet
                st_next.stat[2] = i_code64;
                st_next.stat[1:0] = i_mode;
                // complete now, or after ack in transaction mode
                if (i_xact_mode) begin
                    st_next.ack_wait = 1'b1;
                end else begin
                    st_next.rxc = 1'b1;
                end
            end
        end
        if (st_reg.ack_wait && i_ack_sent) begin
            st_next.ack_wait = 1'b0;
            st_next.rxc = 1'b1;
        end
    end
    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st_reg <= '0;
            st_reg.stat <= `RRSIR_STAT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.rdata = st_reg.rdata;
    assign bus.rvalid = st_reg.rvalid;
    assign bus.buf_data = st_reg.bdata;
    assign bus.buf_valid = st_reg.bvalid;
    assign bus.rx_go = st_reg.go;
    assign bus.irq = |({flags[7], flags[5:0]} & bus.irq_en);
    assign o_rx_active = st_reg.active;
endmodule : rrsir_dev

// file: include/rrsir_consts.svh
// register offsets, field positions and reset values of the receive status block
`ifndef RRSIR_CONSTS_SVH
`define RRSIR_CONSTS_SVH
`define RRSIR_ADDR_IRQ 6'h07
`define RRSIR_ADDR_STAT 6'h08
`define RRSIR_ADDR_COUNT 6'h09
`define RRSIR_ADDR_LEN 6'h0a
`define RRSIR_BIT_OW 7
`define RRSIR_BIT_RSVD 6
`define RRSIR_BIT_FULL 5
`define RRSIR_BIT_HALF 4
`define RRSIR_BIT_NE 3
`define RRSIR_BIT_BERR 2
`define RRSIR_BIT_RXC 1
`define RRSIR_BIT_RXE 0
`define RRSIR_BUF_DEPTH 5'h10
`define RRSIR_HALF_LEVEL 5'h08
`define RRSIR_HALF_BURST 4'h8
`define RRSIR_RESET_BYTE 8'h00
`define RRSIR_STAT_RESET 8'h08
`endif

// file: include/rrsir_pkg.sv
// types shared by both ends of the receive status block
package rrsir_pkg;
    // receive data modes reported in the status register
    typedef enum logic [1:0] {
        RRSIR_MODE_GFSK = 2'h0,
        RRSIR_MODE_OCTAL = 2'h1,
        RRSIR_MODE_DOUBLE = 2'h2,
        RRSIR_MODE_INVALID = 2'h3
    } rrsir_mode_t;
    // host sequencer states
    typedef enum logic [2:0] {
        RRSIR_H_IDLE,
        RRSIR_H_READ_IRQ,
        RRSIR_H_READ_IRQ2,
        RRSIR_H_READ_STAT,
        RRSIR_H_READ_COUNT,
        RRSIR_H_DRAIN
    } rrsir_hstate_t;
endpackage : rrsir_pkg

// file: include/rrsir_if.sv
// register port between receive status device and host
`timescale 1ns/10ps
interface rrsir_if;
    logic rd;          // host read strobe, one cycle
    logic wr;          // host write strobe, one cycle
    logic [5:0] addr;  // register address
    logic [7:0] wdata; // write data
    logic [7:0] rdata; // read data, valid cycle after rd
    logic rvalid;      // read data valid pulse
    logic buf_rd;      // host pops one receive buffer byte
    logic [7:0] buf_data; // popped byte, valid with buf_valid
    logic buf_valid;   // popped byte valid pulse
    logic rx_start;    // host sets receive start, one cycle
    logic rx_go;       // receive start still pending
    logic irq;         // interrupt level, active high
    logic [6:0] irq_en; // receive interrupt enables, host owned
    logic ow_en;       // overwrite enable, host owned
    modport dev (input rd, wr, addr, wdata, buf_rd, rx_start, irq_en, ow_en,
                 output rdata, rvalid, buf_data, buf_valid, rx_go, irq);
    modport host (output rd, wr, addr, wdata, buf_rd, rx_start, irq_en, ow_en,
                  input rdata, rvalid, buf_data, buf_valid, rx_go, irq);
endinterface : rrsir_if

// file: rtl/rrsir_host.sv
// host side sequencer that services receive interrupts
`timescale 1ns/10ps
`include "rrsir_consts.svh"
module rrsir_host
    import rrsir_pkg::*;
(
    input wire logic i_sys_clk,        // system clock
    input wire logic i_rst,            // synchronous reset, active high
    rrsir_if.host bus,                 // device register port
    input wire logic i_start,          // user request to receive
    input wire logic i_ow_en,          // user overwrite enable
    input wire logic i_use_half,       // drain by half flag, else not-empty
    output logic o_busy,               // sequencer running
    output logic [7:0] o_byte,         // byte taken from buffer
    output logic o_byte_valid,         // byte valid pulse
    output logic o_done,               // packet verdict pulse
    output logic o_good,               // verdict good
    output logic [7:0] o_status        // last packet status
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        rrsir_hstate_t fsm;  // sequencer state
        logic issued;        // read in flight
        logic [7:0] irqv;    // first interrupt read
        logic [7:0] taken;   // bytes unloaded
        logic [3:0] burst;   // bytes left in burst
        logic [7:0] status;  // status byte
        logic [7:0] byte_q;  // byte out
        logic bv, done, good;
    } rrsir_hs_t;
    rrsir_hs_t s_reg;
    rrsir_hs_t s_next;
    logic fin;           // complete or error seen
    always_comb begin
        s_next = s_reg;
        s_next.bv = bus.buf_valid;
        s_next.done = 1'b0;
        if (bus.buf_valid) begin
            s_next.byte_q = bus.buf_data;
            s_next.taken = s_reg.taken + 8'h01;
        end
        fin = s_reg.irqv[`RRSIR_BIT_RXC] | s_reg.irqv[`RRSIR_BIT_RXE];
        case (s_reg.fsm)
            RRSIR_H_IDLE: begin
                // arm only after device cleared start
                if (i_start && !bus.rx_go) begin
                    s_next.fsm = RRSIR_H_READ_IRQ;
                    s_next.taken = 8'h00;
                end
            end
            RRSIR_H_READ_IRQ: begin
                if (bus.rvalid) begin
                    s_next.irqv = bus.rdata;
                    s_next.issued = 1'b0;
                    // unload exactly eight on half flag
                    if (bus.rdata[`RRSIR_BIT_HALF] && i_use_half) begin
                        s_next.burst = `RRSIR_HALF_BURST;
                        s_next.fsm = RRSIR_H_DRAIN;
                    end else if (bus.rdata[`RRSIR_BIT_NE] && !i_use_half) begin
                        s_next.burst = 4'h1;
                        s_next.fsm = RRSIR_H_DRAIN;
                    // reread interrupt register after a clean completion with no drain due
                    end else if (bus.rdata[`RRSIR_BIT_RXC] && !bus.rdata[`RRSIR_BIT_RXE]) begin
                        s_next.fsm = RRSIR_H_READ_IRQ2;
                    end else if (bus.rdata[`RRSIR_BIT_RXE]) begin
                        s_next.fsm = RRSIR_H_READ_STAT;
                    end
                end else begin
                    s_next.issued = 1'b1;
                end
            end
            RRSIR_H_READ_IRQ2: begin
                if (bus.rvalid) begin
                    s_next.irqv = s_reg.irqv | bus.rdata;
                    s_next.fsm = RRSIR_H_READ_STAT;
                end
            end
            RRSIR_H_READ_STAT: begin
                if (bus.rvalid) begin
                    s_next.status = bus.rdata;
                    s_next.fsm = RRSIR_H_READ_COUNT;
                end
            end
            RRSIR_H_READ_COUNT: begin
                if (bus.rvalid) begin
                    if (s_reg.taken < bus.rdata) begin
                        s_next.burst = 4'h1;
                        s_next.fsm = RRSIR_H_DRAIN;
                    end else begin
                        s_next.done = 1'b1;
                        // verdict uses complete, error and zero seed
                        s_next.good = s_reg.irqv[`RRSIR_BIT_RXC]
                            && !s_reg.irqv[`RRSIR_BIT_RXE] && !s_reg.status[4];
                        s_next.fsm = RRSIR_H_IDLE;
                    end
                end
            end
            RRSIR_H_DRAIN: begin
                if (bus.buf_valid) begin
                    s_next.burst = s_reg.burst - 4'h1;
                    if (s_reg.burst == 4'h1) begin
                        s_next.fsm = fin ? RRSIR_H_READ_STAT : RRSIR_H_READ_IRQ;
                    end
                end
            end
            default: s_next.fsm = RRSIR_H_IDLE;
        endcase
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    // ------------------------------------------------------------
    // port drive
    // ------------------------------------------------------------
    // one read per wait; strobe only while no answer pending
    assign bus.rd = !bus.rvalid && !s_reg.issued && (s_reg.fsm == RRSIR_H_READ_IRQ
        || s_reg.fsm == RRSIR_H_READ_IRQ2 || s_reg.fsm == RRSIR_H_READ_STAT
        || s_reg.fsm == RRSIR_H_READ_COUNT);
    assign bus.addr = (s_reg.fsm == RRSIR_H_READ_STAT) ? `RRSIR_ADDR_STAT :
        (s_reg.fsm == RRSIR_H_READ_COUNT) ? `RRSIR_ADDR_COUNT : `RRSIR_ADDR_IRQ;
    // no writes are issued; write data held at zero
    assign bus.wr = 1'b0;
    assign bus.wdata = 8'h00;
    assign bus.buf_rd = (s_reg.fsm == RRSIR_H_DRAIN) && !bus.buf_valid && !s_reg.bv;
    assign bus.rx_start = (s_reg.fsm == RRSIR_H_IDLE) && i_start && !bus.rx_go;
    // never both not-empty and half enabled
    assign bus.irq_en = {1'b1, 1'b1, i_use_half, !i_use_half, 3'h7};
    assign bus.ow_en = i_ow_en;
    assign o_busy = (s_reg.fsm != RRSIR_H_IDLE);
    assign o_byte = s_reg.byte_q;
    assign o_byte_valid = s_reg.bv;
    assign o_done = s_reg.done;
    assign o_good = s_reg.good;
    assign o_status = s_reg.status;
endmodule : rrsir_host

// file: tb/rrsir_asserts.sv
// concurrent checks on the register port joining host and device
`timescale 1ns/10ps
`include "rrsir_consts.svh"
module rrsir_asserts (
    input wire logic i_sys_clk, // system clock
    input wire logic i_rst, // synchronous reset
    input wire logic rd, // read strobe
    input wire logic wr, // write strobe
    input wire logic [5:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic [7:0] rdata, // read data
    input wire logic rvalid, // read answer
    input wire logic buf_rd, // pop request
    input wire logic buf_valid, // pop answer
    input wire logic rx_start, // receive start pulse
    input wire logic rx_go, // receive start pending
    input wire logic irq, // interrupt level
    input wire logic [6:0] irq_en // interrupt enables
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    a_read_answer_next: assert property (rd |=> rvalid)
        else $error("read got no answer");
    a_answer_has_cause: assert property (rvalid |-> $past(rd))
        else $error("answer without read");
    a_pop_has_cause: assert property (buf_valid |-> $past(buf_rd))
        else $error("pop answer without pop");
    a_start_sets_go: assert property (rx_start |=> rx_go)
        else $error("receive start not held");
    a_no_restart: assert property (rx_start |-> !rx_go)
        else $error("start set while pending");
    a_rsvd_kept_zero: assert property (wr && addr == `RRSIR_ADDR_IRQ |-> !wdata[6])
        else $error("reserved bit written one");
    a_enables_apart: assert property (!(irq_en[3] && irq_en[4]))
        else $error("not-empty and half enabled together");
    a_irq_masked: assert property (irq_en == 7'h00 |-> !irq)
        else $error("interrupt with all enables off");
    a_full_means_half: assert property (rvalid && $past(rd && addr == `RRSIR_ADDR_IRQ)
        && rdata[5] |-> rdata[4] && rdata[3])
        else $error("full flag without half and not-empty");
    a_half_means_ne: assert property (rvalid && $past(rd && addr == `RRSIR_ADDR_IRQ)
        && rdata[4] |-> rdata[3])
        else $error("half flag without not-empty");
    a_count_idle_read: assert property (rd && addr == `RRSIR_ADDR_COUNT |-> !rx_go)
        else $error("count read while start pending");
endmodule : rrsir_asserts

// file: tb/radio_rx_status_irq_regs_tb_top.sv
// bench: host and device joined, plus a second device driven by bench tasks
`timescale 1ns/10ps
`include "rrsir_consts.svh"
module radio_rx_status_irq_regs_tb_top import rrsir_pkg::*;;
    logic i_sys_clk, i_rst, i_sop, i_len_valid, i_len_bad, i_byte_valid, i_eop, i_crc_bad;
    logic i_crc_zero, i_early_end, i_is_ack, i_expect_ack, i_code64, i_xact_mode, i_ack_sent;
    logic i_start, i_ow_en, i_use_half, o_busy, o_byte_valid, o_done, o_good;
    logic host_done = 1'b0; // sticky host verdict seen
    logic host_good = 1'b0; // sticky host verdict good
    logic [7:0] i_len, i_byte, o_byte, o_status;
    logic [1:0] i_mode;
    int fail_count, samples_checked, k;
    rrsir_if link_a();
    rrsir_if link_b();
    rrsir_dev i_rrsir_dev (.*, .bus(link_a), .o_rx_active());
    rrsir_dev i_rrsir_dev_b (.*, .bus(link_b), .o_rx_active());
    rrsir_host i_rrsir_host (.*, .bus(link_a));
    rrsir_asserts i_rrsir_asserts (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .rd(link_a.rd),
        .wr(link_a.wr), .addr(link_a.addr), .wdata(link_a.wdata), .rdata(link_a.rdata),
        .rvalid(link_a.rvalid), .buf_rd(link_a.buf_rd), .buf_valid(link_a.buf_valid),
        .rx_start(link_a.rx_start), .rx_go(link_a.rx_go), .irq(link_a.irq),
        .irq_en(link_a.irq_en));
    // clock, 8 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // capture the host verdict pulse
    always @(posedge i_sys_clk) begin
        if (o_done === 1'b1) begin
            host_done <= 1'b1;
            host_good <= o_good;
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // register read, one-cycle strobe, bounded wait for the answer
    task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp, input string nm);
        int n;
        @(negedge i_sys_clk);
        link_b.rd = 1'b1;
        link_b.addr = a;
        @(negedge i_sys_clk);
        link_b.rd = 1'b0;
        for (n = 0; n < 4 && link_b.rvalid !== 1'b1; n++) @(negedge i_sys_clk);
        chk(nm, link_b.rdata, exp);
    endtask : rd_reg
    task automatic pop(input logic [7:0] exp);
        int n;
        @(negedge i_sys_clk);
        link_b.buf_rd = 1'b1;
        @(negedge i_sys_clk);
        link_b.buf_rd = 1'b0;
        for (n = 0; n < 4 && link_b.buf_valid !== 1'b1; n++) @(negedge i_sys_clk);
        chk("popped byte", link_b.buf_data, exp);
    endtask : pop
    task automatic go();
        @(negedge i_sys_clk);
        link_b.rx_start = 1'b1;
        @(negedge i_sys_clk);
        link_b.rx_start = 1'b0;
        chk("start pending", {7'h00, link_b.rx_go}, 8'h01);
    endtask : go
    // one packet of n bytes a0, a1 ...; bad gives checksum and type errors
    task automatic pkt(input logic [7:0] n, input logic bad);
        int j;
        i_crc_bad = bad;
        i_is_ack = bad;
        i_len = n;
        @(negedge i_sys_clk);
        i_sop = 1'b1;
        @(negedge i_sys_clk);
        i_sop = 1'b0;
        i_len_valid = 1'b1;
        @(negedge i_sys_clk);
        i_len_valid = 1'b0;
        for (j = 0; j < n; j++) begin
            i_byte_valid = 1'b1;
            i_byte = 8'ha0 + 8'(j);
            @(negedge i_sys_clk);
        end
        i_byte_valid = 1'b0;
        i_eop = 1'b1;
        @(negedge i_sys_clk);
        i_eop = 1'b0;
    endtask : pkt
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // watchdog against a hang
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    // main sequence
    initial begin
        {i_rst, i_sop, i_len_valid, i_len_bad, i_byte_valid, i_eop, i_crc_bad} = 7'h40;
        {i_crc_zero, i_early_end, i_is_ack, i_expect_ack, i_xact_mode, i_ack_sent} = 6'h00;
        {i_code64, i_mode, i_len, i_byte} = {1'b1, RRSIR_MODE_DOUBLE, 16'h0};
        {i_start, i_ow_en, i_use_half, link_b.rd, link_b.wr, link_b.buf_rd} = 6'h00;
        {link_b.addr, link_b.wdata, link_b.rx_start, link_b.ow_en, link_b.irq_en} = 23'h0;
        repeat (8) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        i_start = 1'b1;
        rd_reg(`RRSIR_ADDR_IRQ, 8'h00, "irq reset");
        rd_reg(`RRSIR_ADDR_STAT, `RRSIR_STAT_RESET, "status reset");
        rd_reg(`RRSIR_ADDR_COUNT, 8'h00, "count reset");
        rd_reg(`RRSIR_ADDR_LEN, 8'h00, "length reset");
        go();
        link_b.irq_en = 7'h02;
        pkt(8'h03, 1'b0);
        chk("start cleared", {7'h00, link_b.rx_go}, 8'h00);
        chk("irq raised", {7'h00, link_b.irq}, 8'h01);
        link_b.irq_en = 7'h00;
        #1 chk("irq masked", {7'h00, link_b.irq}, 8'h00);
        rd_reg(`RRSIR_ADDR_COUNT, 8'h03, "count");
        rd_reg(`RRSIR_ADDR_LEN, 8'h03, "length");
        rd_reg(`RRSIR_ADDR_STAT, 8'h06, "status good");
        rd_reg(`RRSIR_ADDR_IRQ, 8'h0a, "irq complete");
        rd_reg(`RRSIR_ADDR_IRQ, 8'h08, "irq reread");
        for (k = 0; k < 3; k++) pop(8'ha0 + 8'(k));
        pop(8'ha2);
        chk("empty pop answer", {7'h00, link_b.buf_valid}, 8'h00);
        rd_reg(`RRSIR_ADDR_IRQ, 8'h04, "buffer error");
        chk("host verdict", {6'h00, host_done, host_good}, 8'h03);
        go();
        pkt(8'h10, 1'b0);
        rd_reg(`RRSIR_ADDR_IRQ, 8'h3a, "buffer full");
        for (k = 0; k < 9; k++) pop(8'ha0 + 8'(k));
        rd_reg(`RRSIR_ADDR_IRQ, 8'h08, "below half");
        link_b.ow_en = 1'b1;
        go();
        pkt(8'h01, 1'b1);
        rd_reg(`RRSIR_ADDR_IRQ, 8'h89, "overwrite");
        rd_reg(`RRSIR_ADDR_STAT, 8'hce, "status bad");
        @(negedge i_sys_clk);
        link_b.wr = 1'b1;
        link_b.addr = `RRSIR_ADDR_IRQ;
        @(negedge i_sys_clk);
        link_b.wr = 1'b0;
        rd_reg(`RRSIR_ADDR_IRQ, 8'h08, "overwrite cleared");
        // transaction mode, zero seed and corrupt length in one packet
        {i_xact_mode, i_crc_zero, i_len_bad} = 3'h7;
        go();
        pkt(8'h02, 1'b0);
        rd_reg(`RRSIR_ADDR_IRQ, 8'h89, "complete waits ack");
        @(negedge i_sys_clk);
        i_ack_sent = 1'b1;
        @(negedge i_sys_clk);
        i_ack_sent = 1'b0;
        rd_reg(`RRSIR_ADDR_IRQ, 8'h8a, "complete after ack");
        rd_reg(`RRSIR_ADDR_LEN, 8'h00, "corrupt length");
        rd_reg(`RRSIR_ADDR_COUNT, 8'h02, "count after bad length");
        rd_reg(`RRSIR_ADDR_STAT, 8'h16, "status zero seed");
        // early end keeps last good code and mode
        {i_xact_mode, i_crc_zero, i_len_bad, i_early_end} = 4'h1;
        go();
        pkt(8'h01, 1'b0);
        rd_reg(`RRSIR_ADDR_STAT, 8'h26, "status early end");
        rd_reg(`RRSIR_ADDR_IRQ, 8'h89, "early end error");
        complete_run();
    end
endmodule : radio_rx_status_irq_regs_tb_top
